// >>> cpu_ctl.sv
// Processor external control: reset sequence, interrupts, halt, lock,
// request/grant, wait loop and I/O cycles. Pins are asynchronous and are
// synchronised here; the register bus and core pulses share clk_i.
`timescale 1ns/100ps
`default_nettype none
module cpu_ctl (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  mode_strap_i,
	input  wire logic                  nmi_i,
	input  wire logic                  maskable_request_i,
	input  wire logic                  test_n_i,
	input  wire logic                  ready_i,
	input  wire logic                  request_grant_pin_i,
	output logic                       request_grant_pin_o,
	output logic                       request_grant_pin_oe_o,
	input  wire logic [15:0]           data_i,
	output cpu_ctl_pkg::bus_pins_s     bus_o
);
	function automatic logic [15:0] lane_in(input logic [15:0] d,
		input logic odd, input logic word);
		lane_in = word ? d : (odd ? {8'h00, d[15:8]} : {8'h00, d[7:0]});
	endfunction
	function automatic logic [15:0] lane_out(input logic [15:0] d,
		input logic odd, input logic word);
		lane_out = (odd && !word) ? {d[7:0], 8'h00} : d;
	endfunction

	// Pin synchronisers: nmi, maskable_request, test_n, ready, rg, strap
	logic [5:0]  s1_ff, s2_ff;
	logic [15:0] d1_ff, d2_ff;
	wire nmi_s = s2_ff[0];
	wire maskable_request_s = s2_ff[1];
	wire test_n_s = s2_ff[2];
	wire ready_s = s2_ff[3];
	wire rg_s = s2_ff[4];
	wire mode_hi = s2_ff[5];

	cpu_ctl_pkg::bus_state_e st_ff, nxt_st;
	cpu_ctl_pkg::cycle_e     kind_ff, nxt_kind;
	cpu_ctl_pkg::bus_pins_s  nxt_bus;
	logic [3:0]  post_cnt_ff;
	logic        nmi_q_ff, nmi_pend_ff, maskable_request_prev_ff, rg_q_ff;
	logic        rg_pend_ff, granted_ff, lock_ff, lock_rel_ff;
	logic        interrupt_ack_strobe_lock_ff, interrupt_ack_strobe_seq_ff, halted_ff, halt_pend_ff;
	logic        waiting_ff, fetch_pend_ff, io_pend_ff, qfull_ff;
	logic [15:0] flags_ff, saved_flags_ff, io_port_ff, io_wdata_ff;
	logic [15:0] io_rdata_ff;
	logic        io_wr_ff, io_word_ff;
	logic [31:0] ctx_ff, saved_ctx_ff;
	logic [9:0]  vector_ff;
	logic [19:0] fetch_addr_ff;

	// Register bus decode
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = req && wb_we_i;
	wire wr_ctrl = wr && wb_adr_i == cpu_ctl_pkg::REG_CTRL;
	wire wr_flags = wr_ctrl && wb_sel_i[1:0] == 2'b11;
	wire wr_pulse = wr_ctrl && wb_sel_i[2];
	wire busy = st_ff != cpu_ctl_pkg::S_IDLE;
	// I/O commands are dropped while one is pending; status bit 0 shows busy or pending
	wire wr_io = wr && wb_adr_i == cpu_ctl_pkg::REG_IO_CMD &&
		!io_pend_ff && wb_sel_i == 4'hf;
	wire wr_iod = wr && wb_adr_i == cpu_ctl_pkg::REG_IO_DATA;
	wire wr_ctx = wr && wb_adr_i == cpu_ctl_pkg::REG_CONTEXT;
	wire p_lock = wr_pulse && wb_dat_i[cpu_ctl_pkg::C_LOCK];
	wire p_lock_end = wr_pulse && wb_dat_i[cpu_ctl_pkg::C_LOCK_END];
	wire p_halt = wr_pulse && wb_dat_i[cpu_ctl_pkg::C_HALT];
	wire p_wait = wr_pulse && wb_dat_i[cpu_ctl_pkg::C_WAIT];
	wire p_bound = wr_pulse && wb_dat_i[cpu_ctl_pkg::C_BOUNDARY];
	wire p_ret = wr_pulse && wb_dat_i[cpu_ctl_pkg::C_RETURN];
	wire [31:0] status_w = {24'h0, qfull_ff, interrupt_ack_strobe_seq_ff,
		granted_ff, lock_ff, nmi_pend_ff, waiting_ff, halted_ff,
		busy || io_pend_ff};
	wire [31:0] rd_mux =
		wb_adr_i == cpu_ctl_pkg::REG_CTRL ?
			{9'h0, qfull_ff, 6'h0, flags_ff} :
		wb_adr_i == cpu_ctl_pkg::REG_IO_CMD ?
			{14'h0, io_word_ff, io_wr_ff, io_port_ff} :
		wb_adr_i == cpu_ctl_pkg::REG_IO_DATA ?
			{16'h0, io_rdata_ff} :
		wb_adr_i == cpu_ctl_pkg::REG_STATUS ? status_w :
		wb_adr_i == cpu_ctl_pkg::REG_VECTOR ? {22'h0, vector_ff} :
		wb_adr_i == cpu_ctl_pkg::REG_CONTEXT ? ctx_ff :
		wb_adr_i == cpu_ctl_pkg::REG_SAVED ? saved_ctx_ff :
		wb_adr_i == cpu_ctl_pkg::REG_SAVED_FLAGS ?
			{16'h0, saved_flags_ff} : 32'h0;

	// Reset sequence and event detection
	wire run = post_cnt_ff == 4'(cpu_ctl_pkg::RST_SEQ_CLKS);
	wire run_start = post_cnt_ff == 4'(cpu_ctl_pkg::RST_SEQ_CLKS - 1);
	wire nmi_edge = nmi_s && !nmi_q_ff &&
		post_cnt_ff >= 4'(cpu_ctl_pkg::NMI_IGNORE_CLKS);
	wire ie = flags_ff[cpu_ctl_pkg::IE_BIT];
	wire lock_any = lock_ff || interrupt_ack_strobe_lock_ff;
	wire take_ok = run && !busy && !granted_ff && !interrupt_ack_strobe_seq_ff &&
		(p_bound || halted_ff || waiting_ff);
	wire nmi_take = take_ok && nmi_pend_ff;
	// Level sampled one clock before the boundary
	wire maskable_request_take = take_ok && !nmi_pend_ff &&
		ie && maskable_request_prev_ff;
	wire any_take = nmi_take || maskable_request_take;
	wire rg_edge = !rg_s && rg_q_ff;
	wire grant = rg_pend_ff && !lock_any && !busy &&
		!interrupt_ack_strobe_seq_ff && !maskable_request_take;
	wire at_t4 = st_ff == cpu_ctl_pkg::S_T4;
	wire inta2_end = at_t4 && kind_ff == cpu_ctl_pkg::K_INTA2;
	wire inta1_end = at_t4 && kind_ff == cpu_ctl_pkg::K_INTA1;
	wire want_fetch = fetch_pend_ff ||
		(waiting_ff && !qfull_ff);
	wire can_start = run && !busy && !granted_ff && !grant;

	// Cycle start and sequencing
	always_comb begin
		nxt_st = st_ff;
		nxt_kind = kind_ff;
		case (st_ff)
		cpu_ctl_pkg::S_IDLE: begin
			if (maskable_request_take) begin
				nxt_st = cpu_ctl_pkg::S_T1;
				nxt_kind = cpu_ctl_pkg::K_INTA1;
			end else if (can_start && !any_take && io_pend_ff) begin
				nxt_st = cpu_ctl_pkg::S_T1;
				nxt_kind = io_wr_ff ? cpu_ctl_pkg::K_IOW :
					cpu_ctl_pkg::K_IOR;
			end else if (can_start && !any_take && halt_pend_ff) begin
				nxt_st = cpu_ctl_pkg::S_T1;
				nxt_kind = cpu_ctl_pkg::K_HALT;
			end else if (can_start && !any_take && want_fetch) begin
				nxt_st = cpu_ctl_pkg::S_T1;
				nxt_kind = cpu_ctl_pkg::K_FETCH;
			end
		end
		cpu_ctl_pkg::S_T1:
			nxt_st = kind_ff == cpu_ctl_pkg::K_HALT ?
				cpu_ctl_pkg::S_IDLE : cpu_ctl_pkg::S_T2;
		cpu_ctl_pkg::S_T2:
			nxt_st = cpu_ctl_pkg::S_T3;
		cpu_ctl_pkg::S_T3, cpu_ctl_pkg::S_TW:
			nxt_st = ready_s ? cpu_ctl_pkg::S_T4 :
				cpu_ctl_pkg::S_TW;
		cpu_ctl_pkg::S_T4: begin
			nxt_st = cpu_ctl_pkg::S_IDLE;
			if (inta1_end) begin
				nxt_st = cpu_ctl_pkg::S_T1;
				nxt_kind = cpu_ctl_pkg::K_INTA2;
			end
		end
		default:
			nxt_st = cpu_ctl_pkg::S_IDLE;
		endcase
	end

	// Pin values, registered one clock behind the state
	wire k_io = kind_ff == cpu_ctl_pkg::K_IOR ||
		kind_ff == cpu_ctl_pkg::K_IOW;
	wire k_interrupt_ack_strobe = kind_ff == cpu_ctl_pkg::K_INTA1 ||
		kind_ff == cpu_ctl_pkg::K_INTA2;
	wire in_t2w = st_ff == cpu_ctl_pkg::S_T2 ||
		st_ff == cpu_ctl_pkg::S_T3 || st_ff == cpu_ctl_pkg::S_TW;
	wire [2:0] code =
		kind_ff == cpu_ctl_pkg::K_IOR ? cpu_ctl_pkg::ST_IOR :
		kind_ff == cpu_ctl_pkg::K_IOW ? cpu_ctl_pkg::ST_IOW :
		kind_ff == cpu_ctl_pkg::K_HALT ? cpu_ctl_pkg::ST_HALT :
		kind_ff == cpu_ctl_pkg::K_FETCH ? cpu_ctl_pkg::ST_FETCH :
		cpu_ctl_pkg::ST_INTERRUPT_ACK_STROBE;
	wire [2:0] status_pins = (!mode_hi && (st_ff == cpu_ctl_pkg::S_T1 ||
		in_t2w)) ? code : cpu_ctl_pkg::ST_PASSIVE;
	// Acknowledge cycles keep the last address on the lines
	wire [19:0] addr_w = k_io ?
		{cpu_ctl_pkg::IO_UPPER, io_port_ff} :
		kind_ff == cpu_ctl_pkg::K_FETCH ? fetch_addr_ff : bus_o.addr;
	assign nxt_bus.ale = st_ff == cpu_ctl_pkg::S_T1 && mode_hi;
	assign nxt_bus.rd_n = !(mode_hi && in_t2w &&
		(kind_ff == cpu_ctl_pkg::K_IOR ||
		kind_ff == cpu_ctl_pkg::K_FETCH));
	assign nxt_bus.wr_n = !(mode_hi && in_t2w &&
		kind_ff == cpu_ctl_pkg::K_IOW);
	assign nxt_bus.interrupt_ack_strobe_n = !(mode_hi && in_t2w && k_interrupt_ack_strobe);
	assign nxt_bus.m_io = kind_ff == cpu_ctl_pkg::K_FETCH;
	assign nxt_bus.bhe_n = k_io ? !(io_word_ff || io_port_ff[0]) :
		kind_ff != cpu_ctl_pkg::K_FETCH;
	assign {nxt_bus.cycle_status_bit2, nxt_bus.cycle_status_bit1,
		nxt_bus.cycle_status_bit0} = status_pins;
	assign nxt_bus.lock_n = !(!mode_hi && lock_any);
	assign nxt_bus.float_out = granted_ff;
	assign nxt_bus.data_oe = kind_ff == cpu_ctl_pkg::K_IOW &&
		(in_t2w || at_t4);
	assign nxt_bus.data = lane_out(io_wdata_ff, io_port_ff[0],
		io_word_ff);
	assign nxt_bus.addr = busy ? addr_w : bus_o.addr;

	always_ff @(posedge clk_i) begin
		s1_ff <= {mode_strap_i, request_grant_pin_i, ready_i, test_n_i,
			maskable_request_i, nmi_i};
		s2_ff <= s1_ff;
		d1_ff <= data_i;
		d2_ff <= d1_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			post_cnt_ff <= 4'h0;
			st_ff <= cpu_ctl_pkg::S_IDLE;
			kind_ff <= cpu_ctl_pkg::K_FETCH;
			nmi_q_ff <= 1'b0;
			maskable_request_prev_ff <= 1'b0;
			rg_q_ff <= 1'b1;
		end else begin
			if (!run)
				post_cnt_ff <= post_cnt_ff + 4'h1;
			st_ff <= nxt_st;
			kind_ff <= nxt_kind;
			nmi_q_ff <= nmi_s;
			maskable_request_prev_ff <= maskable_request_s;
			rg_q_ff <= rg_s;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_o <= '{cycle_status_bit2: 1'b1, cycle_status_bit1: 1'b1,
				cycle_status_bit0: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
				interrupt_ack_strobe_n: 1'b1, bhe_n: 1'b1,
				lock_n: 1'b1, default: '0};
			request_grant_pin_o <= 1'b1;
			request_grant_pin_oe_o <= 1'b0;
		end else begin
			bus_o <= nxt_bus;
			request_grant_pin_o <= !grant;
			request_grant_pin_oe_o <= grant;
		end
	end

	// Pending events: a new event wins over its own clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_pend_ff <= 1'b0;
			rg_pend_ff <= 1'b0;
			granted_ff <= 1'b0;
			halt_pend_ff <= 1'b0;
			halted_ff <= 1'b0;
			fetch_pend_ff <= 1'b0;
			io_pend_ff <= 1'b0;
			waiting_ff <= 1'b0;
		end else begin
			nmi_pend_ff <= nmi_edge || (nmi_pend_ff && !nmi_take);
			rg_pend_ff <= (rg_edge && !granted_ff) ||
				(rg_pend_ff && !grant);
			granted_ff <= grant || (granted_ff && !rg_edge);
			halt_pend_ff <= p_halt || (granted_ff && rg_edge &&
				halted_ff) || (halt_pend_ff && !(can_start &&
				!any_take && !io_pend_ff));
			if (any_take)
				halted_ff <= 1'b0;
			else if (st_ff == cpu_ctl_pkg::S_T1 &&
				kind_ff == cpu_ctl_pkg::K_HALT)
				halted_ff <= 1'b1;
			fetch_pend_ff <= run_start || (any_take && waiting_ff) ||
				(fetch_pend_ff && !(nxt_kind == cpu_ctl_pkg::K_FETCH &&
				nxt_st == cpu_ctl_pkg::S_T1 && !busy));
			io_pend_ff <= wr_io || (io_pend_ff &&
				!(k_io && st_ff == cpu_ctl_pkg::S_T1));
			if (p_wait)
				waiting_ff <= 1'b1;
			else if (!test_n_s && !granted_ff)
				waiting_ff <= 1'b0;
		end
	end

	// Lock and acknowledge sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_ff <= 1'b0;
			lock_rel_ff <= 1'b0;
			interrupt_ack_strobe_lock_ff <= 1'b0;
			interrupt_ack_strobe_seq_ff <= 1'b0;
			vector_ff <= 10'h0;
		end else begin
			lock_rel_ff <= p_lock_end || (lock_rel_ff && busy);
			if (p_lock)
				lock_ff <= 1'b1;
			else if (lock_rel_ff && !busy)
				lock_ff <= 1'b0;
			if (st_ff == cpu_ctl_pkg::S_T2 && k_interrupt_ack_strobe)
				interrupt_ack_strobe_lock_ff <= kind_ff == cpu_ctl_pkg::K_INTA1;
			interrupt_ack_strobe_seq_ff <= maskable_request_take || (interrupt_ack_strobe_seq_ff && !inta2_end);
			if (nmi_take)
				vector_ff <= {cpu_ctl_pkg::NMI_TYPE, 2'b00};
			else if (inta2_end)
				vector_ff <= {d2_ff[7:0], 2'b00};
		end
	end

	// Software state and context save
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_ff <= cpu_ctl_pkg::FLAGS_RESET;
			saved_flags_ff <= cpu_ctl_pkg::FLAGS_RESET;
			ctx_ff <= 32'h0;
			saved_ctx_ff <= 32'h0;
			qfull_ff <= 1'b0;
			io_port_ff <= 16'h0;
			io_wdata_ff <= 16'h0;
			io_rdata_ff <= 16'h0;
			io_wr_ff <= 1'b0;
			io_word_ff <= 1'b0;
			fetch_addr_ff <= cpu_ctl_pkg::BOOT_ADDR;
		end else begin
			if (any_take) begin
				saved_flags_ff <= flags_ff;
				saved_ctx_ff <= ctx_ff;
				flags_ff[cpu_ctl_pkg::IE_BIT] <= 1'b0;
			end else if (p_ret) begin
				flags_ff <= saved_flags_ff;
				ctx_ff <= saved_ctx_ff;
			end else if (wr_flags)
				flags_ff <= wb_dat_i[15:0];
			if (wr_ctx && !any_take && !p_ret)
				ctx_ff <= wb_dat_i;
			if (wr_pulse)
				qfull_ff <= wb_dat_i[cpu_ctl_pkg::C_QFULL];
			if (wr_io) begin
				io_port_ff <= wb_dat_i[15:0];
				io_wr_ff <= wb_dat_i[cpu_ctl_pkg::IO_WRITE];
				io_word_ff <= wb_dat_i[cpu_ctl_pkg::IO_WORD];
			end
			if (wr_iod)
				io_wdata_ff <= wb_dat_i[15:0];
			if (at_t4 && kind_ff == cpu_ctl_pkg::K_IOR)
				io_rdata_ff <= lane_in(d2_ff, io_port_ff[0],
					io_word_ff);
			if (at_t4 && kind_ff == cpu_ctl_pkg::K_FETCH)
				fetch_addr_ff <= fetch_addr_ff + cpu_ctl_pkg::FETCH_STEP;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_io_upper_zero: assert property (
		nxt_bus.ale && !nxt_bus.m_io && k_io |=>
		bus_o.addr[19:16] == 4'h0)
		else $error("I/O cycle with nonzero upper address");
	a_reset_seq_len: assert property (
		$fell(rst_i) |-> !run [*7] ##1 run)
		else $error("Reset sequence length wrong");
	a_boot_fetch: assert property (
		$rose(run) |-> fetch_addr_ff == cpu_ctl_pkg::BOOT_ADDR)
		else $error("First fetch not at boot address");
	a_nmi_ignored: assert property (
		post_cnt_ff < 4'h2 |=> !nmi_pend_ff)
		else $error("Early non-maskable edge accepted");
	a_nmi_priority: assert property (
		nmi_take |-> !maskable_request_take ##1 vector_ff == 10'h008)
		else $error("Non-maskable priority or type wrong");
	a_vec_scale: assert property (
		inta2_end |=> vector_ff == {$past(d2_ff[7:0]), 2'b00})
		else $error("Vector pointer not type times four");
	a_ie_cleared: assert property (
		any_take |=> !flags_ff[cpu_ctl_pkg::IE_BIT] &&
		saved_flags_ff == $past(flags_ff))
		else $error("Enable flag not cleared on response");
	a_lock_no_grant: assert property (
		lock_any |-> !grant)
		else $error("Grant given while locked");
	a_wait_state: assert property (
		st_ff == cpu_ctl_pkg::S_T3 && !ready_s |=>
		st_ff == cpu_ctl_pkg::S_TW)
		else $error("No wait state while not ready");
	a_halt_ale: assert property (
		st_ff == cpu_ctl_pkg::S_T1 && kind_ff == cpu_ctl_pkg::K_HALT &&
		mode_hi |=> bus_o.ale && bus_o.rd_n && bus_o.wr_n)
		else $error("Halt latch pulse wrong");
endmodule
`default_nettype wire

// >>> cpu_ctl_pkg.sv
// Constants, types and register map of the processor control unit.
// Assumes one 200 MHz clock and a classic Wishbone register bus.
package cpu_ctl_pkg;
	localparam int        RST_SEQ_CLKS = 7;
	localparam int        NMI_IGNORE_CLKS = 2;
	localparam logic [19:0] BOOT_ADDR = 20'hffff0;
	localparam logic [7:0] NMI_TYPE = 8'h02;
	localparam logic [3:0] IO_UPPER = 4'h0;
	localparam logic [19:0] FETCH_STEP = 20'h00002;
	// Encoded cycle status
	localparam logic [2:0] ST_INTERRUPT_ACK_STROBE = 3'h0;
	localparam logic [2:0] ST_IOR = 3'h1;
	localparam logic [2:0] ST_IOW = 3'h2;
	localparam logic [2:0] ST_HALT = 3'h3;
	localparam logic [2:0] ST_FETCH = 3'h4;
	localparam logic [2:0] ST_PASSIVE = 3'h7;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_IO_CMD = 8'h04;
	localparam logic [7:0] REG_IO_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_VECTOR = 8'h10;
	localparam logic [7:0] REG_CONTEXT = 8'h14;
	localparam logic [7:0] REG_SAVED = 8'h18;
	localparam logic [7:0] REG_SAVED_FLAGS = 8'h1c;
	// Control register fields
	localparam int IE_BIT = 9;
	localparam int C_LOCK = 16;
	localparam int C_LOCK_END = 17;
	localparam int C_HALT = 18;
	localparam int C_WAIT = 19;
	localparam int C_BOUNDARY = 20;
	localparam int C_RETURN = 21;
	localparam int C_QFULL = 22;
	// I/O command fields
	localparam int IO_WRITE = 16;
	localparam int IO_WORD = 17;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	typedef enum {S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4} bus_state_e;
	typedef enum {K_IOR, K_IOW, K_INTA1, K_INTA2, K_HALT, K_FETCH} cycle_e;
	typedef struct packed {
		logic        ale;
		logic        rd_n;
		logic        wr_n;
		logic        interrupt_ack_strobe_n;
		logic        m_io;
		logic        bhe_n;
		logic        cycle_status_bit2;
		logic        cycle_status_bit1;
		logic        cycle_status_bit0;
		logic        lock_n;
		logic        float_out;
		logic        data_oe;
		logic [19:0] addr;
		logic [15:0] data;
	} bus_pins_s;
endpackage

// >>> ctl_far_side.sv
// Far-side model: interrupt controller, ready source and data lines.
// Assumes the registered pins of cpu_ctl and one shared clock.
`timescale 1ns/100ps
`default_nettype none
module ctl_far_side (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   raise_i,
	input  wire logic                   slow_i,
	input  wire logic [7:0]             type_i,
	input  wire cpu_ctl_pkg::bus_pins_s bus_i,
	output logic                        maskable_request_o,
	output logic                        ready_o,
	output logic [15:0]                 data_o
);
	logic       ack_ff;
	logic [3:0] cnt_ff;
	wire logic [2:0] st_w = {bus_i.cycle_status_bit2,
		bus_i.cycle_status_bit1, bus_i.cycle_status_bit0};
	wire logic ack_w = !bus_i.interrupt_ack_strobe_n ||
		st_w == cpu_ctl_pkg::ST_INTERRUPT_ACK_STROBE;
	wire logic act_w = ack_w || bus_i.ale || !bus_i.rd_n ||
		!bus_i.wr_n || st_w != cpu_ctl_pkg::ST_PASSIVE;

	always_ff @(posedge clk_i) begin
		ack_ff <= ack_w;
		if (rst_i) begin
			maskable_request_o <= 1'b0;
			ready_o <= 1'b0;
			cnt_ff <= 4'h0;
			data_o <= 16'h00ff;
		end else begin
			if (raise_i)
				maskable_request_o <= 1'b1;
			else if (ack_ff && !ack_w)
				maskable_request_o <= 1'b0;
			if (!act_w)
				cnt_ff <= 4'h0;
			else if (cnt_ff != 4'hf)
				cnt_ff <= cnt_ff + 4'h1;
			// One ready pulse per cycle, late enough for data to cross
			// the input synchronisers; slow mode adds wait states
			ready_o <= act_w && cnt_ff == (slow_i ? 4'h5 : 4'h3);
			// Undriven lanes keep changing so stale data never matches
			data_o <= ack_w ? {~type_i, type_i} : ~data_o;
		end
	end
endmodule
`default_nettype wire

// >>> test_cpu_reset_interrupt_halt_control.sv
// Self-checking bench for cpu_ctl with the far-side model.
// Assumes a 200 MHz clock and a classic Wishbone register bus.
`timescale 1ns/100ps
`default_nettype none
module test_cpu_reset_interrupt_halt_control;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic mode_strap_i = 1, nmi_i = 0, raise = 0, slow = 0;
	logic test_n_i = 1, request_grant_pin_i = 1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, q, wb_dat_o;
	logic        wb_ack_o, maskable_request_i, ready_i;
	logic        request_grant_pin_o, request_grant_pin_oe_o, lock_seen = 0;
	logic [15:0] data_i;
	logic [2:0]  st_prev;
	cpu_ctl_pkg::bus_pins_s bus_o;
	int err_count = 0, n_checks = 0, n_ack = 0, i;
	wire logic [2:0] st_w = {bus_o.cycle_status_bit2,
		bus_o.cycle_status_bit1, bus_o.cycle_status_bit0};

	cpu_ctl dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_strap_i, .nmi_i,
		.maskable_request_i, .test_n_i, .ready_i, .request_grant_pin_i,
		.request_grant_pin_o, .request_grant_pin_oe_o, .data_i, .bus_o);
	ctl_far_side far (.clk_i, .rst_i, .raise_i(raise), .slow_i(slow),
		.type_i(8'h47), .bus_i(bus_o), .maskable_request_o(maskable_request_i),
		.ready_o(ready_i), .data_o(data_i));

	always #2.5 clk_i = ~clk_i;

	// Counts acknowledge cycles by their status entry
	always @(posedge clk_i) begin
		st_prev <= st_w;
		if (st_w === cpu_ctl_pkg::ST_INTERRUPT_ACK_STROBE && st_prev !== cpu_ctl_pkg::ST_INTERRUPT_ACK_STROBE)
			n_ack <= n_ack + 1;
		if (bus_o.lock_n === 1'b0)
			lock_seen <= 1'b1;
	end

	task chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task give_up(input logic hit, input string m);
		if (hit) begin
			chk(1'b0, m);
			finish_test;
		end
	endtask

	task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w;
		wb_adr_i <= a; wb_sel_i <= s; wb_dat_i <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		give_up(i == 20, "no bus ack");
		q = wb_dat_o;
		wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
	endtask

	task poll(input int b, input logic v);
		for (int k = 0; k < 60; k++) begin
			wb(0, cpu_ctl_pkg::REG_STATUS, 4'hf, 0);
			if (q[b] === v)
				return;
		end
		give_up(1'b1, "status wait");
	endtask

	task t_boot;
		for (i = 0; i < 40 && bus_o.ale !== 1'b1; i++) @(posedge clk_i);
		give_up(i == 40, "no boot cycle");
		chk(i >= cpu_ctl_pkg::RST_SEQ_CLKS, "boot too early");
		chk(bus_o.addr === cpu_ctl_pkg::BOOT_ADDR, "boot address");
		$display("t_boot done");
	endtask

	task t_io(input logic [15:0] p);
		poll(0, 0);
		wb(1, cpu_ctl_pkg::REG_IO_DATA, 4'hf, 32'h0000a5a5);
		wb(1, cpu_ctl_pkg::REG_IO_CMD, 4'hf, {14'h0, 1'b0, 1'b1, p});
		for (i = 0; i < 40 && bus_o.ale !== 1'b1; i++) @(posedge clk_i);
		give_up(i == 40, "no io cycle");
		chk(bus_o.addr === {cpu_ctl_pkg::IO_UPPER, p}, "io address");
		chk(bus_o.m_io === 1'b0 && bus_o.bhe_n === !p[0], "io lanes");
		for (i = 0; i < 10 && bus_o.wr_n !== 1'b0; i++) @(posedge clk_i);
		give_up(i == 10, "no write strobe");
		chk((p[0] ? bus_o.data[15:8] : bus_o.data[7:0]) === 8'ha5, "lane");
		chk(bus_o.rd_n === 1'b1, "read strobe during write");
		$display("t_io done");
	endtask

	task t_irq;
		wb(1, cpu_ctl_pkg::REG_CTRL, 4'h3, 32'h200);
		wb(1, cpu_ctl_pkg::REG_CTRL, 4'h4, 32'h1 << cpu_ctl_pkg::C_HALT);
		for (i = 0; i < 40 && st_w !== cpu_ctl_pkg::ST_HALT; i++)
			@(posedge clk_i);
		chk(st_w === cpu_ctl_pkg::ST_HALT, "halt status");
		poll(1, 1);
		repeat (20) @(posedge clk_i);
		wb(0, cpu_ctl_pkg::REG_STATUS, 4'hf, 0);
		chk(q[1] === 1'b1, "halt left early");
		raise <= 1;
		@(posedge clk_i);
		raise <= 0;
		poll(1, 0);
		poll(6, 0);
		chk(n_ack == 2 && lock_seen === 1'b1, "ack pair");
		wb(0, cpu_ctl_pkg::REG_VECTOR, 4'hf, 0);
		chk(q[9:0] === {8'h47, 2'b00}, "vector");
		wb(0, cpu_ctl_pkg::REG_CTRL, 4'hf, 0);
		chk(q[cpu_ctl_pkg::IE_BIT] === 1'b0, "enable kept");
		wb(0, cpu_ctl_pkg::REG_SAVED_FLAGS, 4'hf, 0);
		chk(q[cpu_ctl_pkg::IE_BIT] === 1'b1, "saved flags");
		wb(1, cpu_ctl_pkg::REG_CTRL, 4'h4, 32'h1 << cpu_ctl_pkg::C_RETURN);
		wb(0, cpu_ctl_pkg::REG_CTRL, 4'hf, 0);
		chk(q[cpu_ctl_pkg::IE_BIT] === 1'b1, "return restore");
		$display("t_irq done");
	endtask

	// Both requests pending at one boundary
	task t_nmi;
		nmi_i <= 1;
		raise <= 1;
		@(posedge clk_i);
		raise <= 0;
		repeat (3) @(posedge clk_i);
		nmi_i <= 0;
		wb(1, cpu_ctl_pkg::REG_CTRL, 4'h4, 32'h1 << cpu_ctl_pkg::C_BOUNDARY);
		poll(3, 0);
		wb(0, cpu_ctl_pkg::REG_VECTOR, 4'hf, 0);
		chk(q[9:0] === 10'h008, "nmi vector");
		chk(n_ack == 2, "nmi ran ack cycles");
		wb(0, 8'h20, 4'hf, 0);
		chk(q === 32'h0, "unmapped read");
		$display("t_nmi done");
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		t_boot;
		t_io(16'hbeef);
		slow <= 1;
		t_io(16'h1234);
		@(posedge clk_i);
		rst_i <= 1;
		mode_strap_i <= 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		t_irq;
		t_nmi;
		finish_test;
	end
endmodule
`default_nettype wire
